// File: slmcs_pkg.sv
/*
 * Constants and carrier types for the line command sequencer.
 * Assumes a single core clock domain; used by slmcs_top, its checker and the bench.
 */
`default_nettype none

package slmcs_pkg;

    // =========================================================
    // Host-side command codes (byte after the write address)
    // =========================================================
    localparam logic [7:0] CMD_LINE_RESET  = 8'hb4;
    localparam logic [7:0] CMD_SINGLE_SLOT = 8'h87;
    localparam logic [7:0] CMD_WRITE_BYTE  = 8'ha5;
    localparam logic [7:0] CMD_PORT_ADJUST = 8'hc3;
    localparam logic [7:0] CMD_POINTER_SET = 8'he1;

    // =========================================================
    // Read pointer codes
    // =========================================================
    localparam logic [7:0] PTR_CODE_STATUS = 8'hf0;
    localparam logic [7:0] PTR_CODE_PORT   = 8'hb4;

    // =========================================================
    // Status byte bit positions
    // =========================================================
    localparam int STS_BUSY_BIT  = 0;
    localparam int STS_PRES_BIT  = 1;
    localparam int STS_SHORT_BIT = 2;
    localparam int STS_SLOT_BIT  = 5;

    // =========================================================
    // Port adjust control byte layout and defaults
    // =========================================================
    localparam int         PADJ_SEL_LSB   = 5;
    localparam int         PADJ_VAL_W     = 4;
    localparam int         SLOT_VAL_BIT   = 7;
    localparam logic [3:0] PORT_PARAM_RST = 4'h6;

    // =========================================================
    // Host bus framing
    // =========================================================
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [1:0] {
        SLMCS_OP_RESET,
        SLMCS_OP_SLOT,
        SLMCS_OP_WRITE
    } slmcs_op_t;

    typedef enum logic {
        SLMCS_PTR_STATUS,
        SLMCS_PTR_PORT
    } slmcs_ptr_t;

    typedef struct packed {
        slmcs_op_t  op;
        logic [7:0] data;
    } slmcs_line_cmd_t;

    typedef struct packed {
        logic presence;
        logic short_det;
        logic slot_bit;
    } slmcs_line_res_t;

endpackage

`default_nettype wire

// File: slmcs_top.sv
/*
 * Command sequencer of a two-wire-host to single-line bridge: host bus slave,
 * command decode, busy tracking, status and port parameter readback.
 * Assumes a line waveform engine on core_clk that drains line commands and
 * pulses line_done when the whole waveform including recovery is over.
 */
// Notes on behaviour
// - Accepted port adjust command points the read pointer at port parameters.
// - Port reads return successive parameter bytes while the host acknowledges.
// - Line reset outcome is readable in status after completion.
// - Status byte is refreshed on every read byte for busy polling.
// - Busy refuses line command codes with no acknowledge and no execution.
// - Single slot parameter byte is acknowledged; result read from status.
// - Slot result is in status by the time busy falls.
// - Write byte shifts one byte out, captures nothing, busy marks completion.
// - Port adjust control byte is always acknowledged once the code is taken.
`timescale 1ns/100ps
`default_nettype none

module slmcs_top
    import slmcs_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR  = 7'h18,
    parameter int         N_PORT      = 4,
    parameter int         BUF_DEPTH   = 2
)(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // Host bus pins
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe,
    // Line engine command stream
    output logic                       line_cmd_valid,
    input  wire logic                  line_cmd_ready,
    output slmcs_line_cmd_t            line_cmd,
    // Line engine completion
    input  wire logic                  line_done,
    input  wire slmcs_line_res_t       line_res,
    // Port timing parameters and busy flag
    output logic [N_PORT*PADJ_VAL_W-1:0] port_params,
    output logic                       line_busy_flag
);

    localparam int PIW = (N_PORT > 1) ? $clog2(N_PORT) : 1;
    localparam int BPW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } slmcs_state_t;

    // =========================================================
    // Pin synchronisers and edge detection
    // =========================================================
    logic [2:0] scl_q;
    logic [2:0] sda_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end
        else
        begin
            scl_q <= {scl_q[1:0], scl_i};
            sda_q <= {sda_q[1:0], sda_i};
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise  = scl_q[1] & ~scl_q[2];
    assign scl_fall  = ~scl_q[1] & scl_q[2];
    assign bus_start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    assign bus_stop  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

    // =========================================================
    // Two-entry command buffer
    // =========================================================
    slmcs_line_cmd_t        buf_mem_q [BUF_DEPTH];
    logic [BPW-1:0]         buf_wr_q;
    logic [BPW-1:0]         buf_rd_q;
    logic [BPW:0]           buf_cnt_q;
    logic                   buf_in_ready;
    logic                   enq;
    slmcs_line_cmd_t        enq_cmd;
    logic                   deq;

    assign buf_in_ready   = (buf_cnt_q != (BPW+1)'(BUF_DEPTH));
    assign line_cmd_valid = (buf_cnt_q != '0);
    assign line_cmd       = buf_mem_q[buf_rd_q];
    assign deq            = line_cmd_valid & line_cmd_ready;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_wr_q  <= '0;
            buf_rd_q  <= '0;
            buf_cnt_q <= '0;
        end
        else
        begin
            if (enq && buf_in_ready)
                buf_wr_q <= (buf_wr_q == BPW'(BUF_DEPTH-1)) ? '0 : buf_wr_q + 1'b1;
            if (deq)
                buf_rd_q <= (buf_rd_q == BPW'(BUF_DEPTH-1)) ? '0 : buf_rd_q + 1'b1;
            buf_cnt_q <= buf_cnt_q + (BPW+1)'(enq && buf_in_ready) - (BPW+1)'(deq);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (enq && buf_in_ready)
            buf_mem_q[buf_wr_q] <= enq_cmd;
    end

    // =========================================================
    // Host bus byte engine
    // =========================================================
    slmcs_state_t state_q;
    logic [7:0]   shift_q;
    logic [3:0]   bit_cnt_q;
    logic         first_q;
    logic         rd_q;
    logic [1:0]   byte_idx_q;
    logic [7:0]   cmd_q;
    logic         mack_q;
    logic         busy_q;
    logic         rx_ack;
    slmcs_ptr_t   ptr_q;
    logic [PIW-1:0] pidx_q;
    logic [7:0]   status;
    logic [7:0]   rd_byte;
    logic         pres_q;
    logic         short_q;
    logic         slot_q;
    slmcs_op_t    last_op_q;
    logic [PADJ_VAL_W-1:0] port_q [N_PORT];

    logic line_code;
    logic rx_done;
    assign line_code = (shift_q == CMD_LINE_RESET) || (shift_q == CMD_SINGLE_SLOT)
                    || (shift_q == CMD_WRITE_BYTE);
    assign rx_done   = (state_q == ST_RX) && scl_fall && (bit_cnt_q == BITS_PER_BYTE);

    // Acknowledge decision for a received byte
    always_comb
    begin
        rx_ack     = 1'b0;
        enq        = 1'b0;
        enq_cmd.op   = SLMCS_OP_RESET;
        enq_cmd.data = shift_q;
        if (first_q)
            rx_ack = (shift_q[7:1] == SLAVE_ADDR);
        else if (byte_idx_q == 2'h0)
        begin
            if (line_code)
                rx_ack = ~busy_q & buf_in_ready;
            else if (shift_q == CMD_PORT_ADJUST)
                rx_ack = ~busy_q;
            else
                rx_ack = (shift_q == CMD_POINTER_SET);
            enq = rx_ack & (shift_q == CMD_LINE_RESET);
        end
        else if (byte_idx_q == 2'h1)
        begin
            case (cmd_q)
                CMD_SINGLE_SLOT:
                begin
                    rx_ack     = buf_in_ready;
                    enq        = buf_in_ready;
                    enq_cmd.op = SLMCS_OP_SLOT;
                end
                CMD_WRITE_BYTE:
                begin
                    rx_ack     = buf_in_ready;
                    enq        = buf_in_ready;
                    enq_cmd.op = SLMCS_OP_WRITE;
                end
                CMD_PORT_ADJUST: rx_ack = 1'b1;
                CMD_POINTER_SET: rx_ack = (shift_q == PTR_CODE_STATUS)
                                       || (shift_q == PTR_CODE_PORT);
                default:         rx_ack = 1'b0;
            endcase
        end
        enq = enq & rx_done;
    end

    // Status byte, sampled fresh for every read byte
    always_comb
    begin
        status                = 8'h00;
        status[STS_BUSY_BIT]  = busy_q;
        status[STS_PRES_BIT]  = pres_q;
        status[STS_SHORT_BIT] = short_q;
        status[STS_SLOT_BIT]  = slot_q;
        rd_byte = (ptr_q == SLMCS_PTR_PORT) ? 8'(port_q[pidx_q]) : status;
    end

    // Bus state and shifting
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q    <= ST_IDLE;
            shift_q    <= 8'h00;
            bit_cnt_q  <= 4'h0;
            first_q    <= 1'b0;
            rd_q       <= 1'b0;
            byte_idx_q <= 2'h0;
            cmd_q      <= 8'h00;
            mack_q     <= 1'b0;
            sda_oe     <= 1'b0;
        end
        else if (bus_start)
        begin
            state_q   <= ST_RX;
            bit_cnt_q <= 4'h0;
            first_q   <= 1'b1;
            sda_oe    <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_q <= ST_IDLE;
            sda_oe  <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_RX:
                begin
                    if (scl_rise && bit_cnt_q != BITS_PER_BYTE)
                    begin
                        shift_q   <= {shift_q[6:0], sda_q[1]};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    if (rx_done)
                    begin
                        sda_oe    <= rx_ack;
                        state_q   <= ST_RX_ACK;
                        bit_cnt_q <= 4'h0;
                        if (first_q)
                        begin
                            rd_q       <= shift_q[0];
                            byte_idx_q <= 2'h0;
                        end
                        else
                        begin
                            if (byte_idx_q == 2'h0)
                                cmd_q <= shift_q;
                            if (byte_idx_q != 2'h3)
                                byte_idx_q <= byte_idx_q + 2'h1;
                        end
                        mack_q <= rx_ack;
                    end
                end
                ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        first_q <= 1'b0;
                        if (!mack_q)
                        begin
                            sda_oe  <= 1'b0;
                            state_q <= ST_IDLE;
                        end
                        else if (rd_q)
                        begin
                            shift_q   <= rd_byte;
                            sda_oe    <= ~rd_byte[7];
                            bit_cnt_q <= 4'h1;
                            state_q   <= ST_TX;
                        end
                        else
                        begin
                            sda_oe  <= 1'b0;
                            state_q <= ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_q == BITS_PER_BYTE)
                        begin
                            sda_oe  <= 1'b0;
                            state_q <= ST_TX_ACK;
                        end
                        else
                        begin
                            sda_oe    <= ~shift_q[6];
                            shift_q   <= {shift_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                        mack_q <= ~sda_q[1];
                    if (scl_fall)
                    begin
                        if (mack_q)
                        begin
                            shift_q   <= rd_byte;
                            sda_oe    <= ~rd_byte[7];
                            bit_cnt_q <= 4'h1;
                            state_q   <= ST_TX;
                        end
                        else
                            state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign sda_o = 1'b0;

    // =========================================================
    // Read pointer and port parameter index
    // =========================================================
    logic adj_code_taken;
    logic ptr_set_taken;
    logic tx_next;
    assign adj_code_taken = rx_done && rx_ack && !first_q && (byte_idx_q == 2'h0)
                          && (shift_q == CMD_PORT_ADJUST);
    assign ptr_set_taken  = rx_done && rx_ack && !first_q && (byte_idx_q == 2'h1)
                          && (cmd_q == CMD_POINTER_SET);
    assign tx_next = (state_q == ST_TX) && scl_fall && (bit_cnt_q == BITS_PER_BYTE);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptr_q  <= SLMCS_PTR_STATUS;
            pidx_q <= '0;
        end
        else if (adj_code_taken)
        begin
            ptr_q  <= SLMCS_PTR_PORT;
            pidx_q <= '0;
        end
        else if (ptr_set_taken)
        begin
            ptr_q  <= (shift_q == PTR_CODE_PORT) ? SLMCS_PTR_PORT : SLMCS_PTR_STATUS;
            pidx_q <= '0;
        end
        else if (enq)
            ptr_q <= SLMCS_PTR_STATUS;
        else if (tx_next && ptr_q == SLMCS_PTR_PORT)
            pidx_q <= (pidx_q == PIW'(N_PORT-1)) ? '0 : pidx_q + 1'b1;
    end

    // =========================================================
    // Port parameter store
    // =========================================================
    logic adj_ctrl_taken;
    assign adj_ctrl_taken = rx_done && !first_q && (byte_idx_q == 2'h1)
                          && (cmd_q == CMD_PORT_ADJUST);

    genvar gi;
    generate
        for (gi = 0; gi < N_PORT; gi++)
        begin : g_port
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                    port_q[gi] <= PORT_PARAM_RST;
                else if (adj_ctrl_taken && shift_q[7:PADJ_SEL_LSB] == 3'(gi))
                    port_q[gi] <= shift_q[PADJ_VAL_W-1:0];
            end
            assign port_params[gi*PADJ_VAL_W +: PADJ_VAL_W] = port_q[gi];
        end
    endgenerate

    // =========================================================
    // Busy flag and line results
    // =========================================================
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q    <= 1'b0;
            last_op_q <= SLMCS_OP_RESET;
        end
        else if (enq)
        begin
            busy_q    <= 1'b1;
            last_op_q <= enq_cmd.op;
        end
        else if (line_done)
            busy_q <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pres_q  <= 1'b0;
            short_q <= 1'b0;
            slot_q  <= 1'b0;
        end
        else if (line_done && busy_q)
        begin
            if (last_op_q == SLMCS_OP_RESET)
            begin
                pres_q  <= line_res.presence;
                short_q <= line_res.short_det;
            end
            else if (last_op_q == SLMCS_OP_SLOT)
                slot_q <= line_res.slot_bit;
        end
    end

    assign line_busy_flag = busy_q;

endmodule // slmcs_top

`default_nettype wire

// File: slmcs_top_sva.sv
/* Checker for the command stream and busy flag of slmcs_top.
   Assumes one core_clk domain with rst_n active low; bound below. */
`timescale 1ns/100ps
`default_nettype none

module slmcs_top_sva
    import slmcs_pkg::*;
#(
    parameter int N_PORT = 4
)(
    // Clock and reset
    input wire logic                          core_clk,
    input wire logic                          rst_n,
    // Watched ports
    input wire logic                          line_cmd_valid,
    input wire logic                          line_cmd_ready,
    input wire slmcs_line_cmd_t               line_cmd,
    input wire logic                          line_done,
    input wire logic [N_PORT*PADJ_VAL_W-1:0]  port_params,
    input wire logic                          line_busy_flag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // =========================================================
    // Busy tracking
    // =========================================================
    busy_needs_done_a: assert property ($fell(line_busy_flag) |-> $past(line_done))
        else $error("busy cleared without completion");
    done_clears_a: assert property (line_done && line_busy_flag |=> !line_busy_flag)
        else $error("busy stayed after completion");
    busy_with_cmd_a: assert property ($rose(line_busy_flag) |-> line_cmd_valid)
        else $error("busy set without a queued command");

    // =========================================================
    // Command stream and port parameters
    // =========================================================
    valid_busy_a: assert property (line_cmd_valid |-> line_busy_flag)
        else $error("command queued while not busy");
    cmd_hold_a: assert property (line_cmd_valid && !line_cmd_ready
        |=> line_cmd_valid && $stable(line_cmd))
        else $error("command dropped while stalled");
    one_out_a: assert property (line_cmd_valid && line_cmd_ready |=> !line_cmd_valid)
        else $error("second command outstanding");
    enq_idle_a: assert property ($rose(line_cmd_valid) |-> $rose(line_busy_flag))
        else $error("command accepted while busy");
    port_idle_a: assert property (!$stable(port_params) |-> !$past(line_busy_flag))
        else $error("port parameters changed while busy");

    cover property (line_cmd_valid && line_cmd_ready);
    cover property (line_done && line_busy_flag);
    cover property (!$stable(port_params));
endmodule // slmcs_top_sva

bind slmcs_top slmcs_top_sva #(.N_PORT(N_PORT)) u_sva (
    .core_clk(core_clk), .rst_n(rst_n), .line_cmd_valid(line_cmd_valid),
    .line_cmd_ready(line_cmd_ready), .line_cmd(line_cmd), .line_done(line_done),
    .port_params(port_params), .line_busy_flag(line_busy_flag));

`default_nettype wire

// File: slmcs_host_model.sv
/* Two-wire bus host model: start, stop, byte write and byte read.
   Assumes a pulled-up data wire built by the bench; 400 ns bit time. */
`timescale 1ns/100ps
`default_nettype none

module slmcs_host_model (
    // Bus pins
    output var logic  scl,
    output var logic  sda_drv,
    input  wire logic sda_bus
);
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic bit_io(input logic b, output logic s);
        sda_drv = b;
        #100;
        scl = 1'b1;
        #200;
        s = sda_bus;
        scl = 1'b0;
        #100;
    endtask

    task automatic start();
        sda_drv = 1'b1;
        #100;
        scl = 1'b1;
        #200;
        sda_drv = 1'b0;
        #200;
        scl = 1'b0;
        #100;
    endtask

    task automatic stop();
        sda_drv = 1'b0;
        #100;
        scl = 1'b1;
        #200;
        sda_drv = 1'b1;
        #200;
    endtask

    task automatic tx(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic rx(input logic ack_it, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~ack_it, s);
    endtask
endmodule // slmcs_host_model

`default_nettype wire

// File: slmcs_tb.sv
/* Self-checking bench for slmcs_top with a host model and a line engine.
   Assumes the checker is bound from its own file. */
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import slmcs_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic eng_rdy = 1'b1;
    logic line_done = 1'b0;
    slmcs_line_res_t line_res = 3'b000;
    wire logic scl, sda_drv, sda_bus, sda_o, sda_oe, line_cmd_valid, busy;
    slmcs_line_cmd_t line_cmd, got_cmd;
    logic [15:0] port_params;
    int eng_len = 40, eng_cnt = 0, n_cmds = 0, fail_count = 0, comparisons = 0;
    assign sda_bus = sda_drv & (sda_oe ? sda_o : 1'b1);

    always #25 core_clk = ~core_clk;
    slmcs_top #(.N_PORT(4)) dut (.core_clk(core_clk), .rst_n(rst_n), .scl_i(scl),
        .sda_i(sda_bus), .sda_o(sda_o), .sda_oe(sda_oe), .line_cmd_valid(line_cmd_valid),
        .line_cmd_ready(eng_rdy), .line_cmd(line_cmd), .line_done(line_done),
        .line_res(line_res), .port_params(port_params), .line_busy_flag(busy));
    slmcs_host_model host (.scl(scl), .sda_drv(sda_drv), .sda_bus(sda_bus));

    // =========================================================
    // Line engine: takes a command, finishes eng_len cycles later
    // =========================================================
    always @(posedge core_clk)
    begin
        line_done <= 1'b0;
        if (line_cmd_valid && eng_rdy)
        begin
            got_cmd <= line_cmd;
            n_cmds <= n_cmds + 1;
            eng_cnt <= eng_len;
        end
        else if (eng_cnt == 1)
            line_done <= 1'b1;
        if (eng_cnt > 0 && !(line_cmd_valid && eng_rdy))
            eng_cnt <= eng_cnt - 1;
    end

    // =========================================================
    // Shared tasks
    // =========================================================
    task automatic report_and_stop();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic bail();
        fail_count++;
        $display("BAD %0t wait ran out", $time);
        report_and_stop();
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t byte %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t flag %b want %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] code, input logic [7:0] prm, input logic two,
                      output logic a_code, output logic a_prm);
        logic a;
        host.start();
        host.tx(8'h30, a);
        host.tx(code, a_code);
        a_prm = 1'b0;
        if (a_code && two)
            host.tx(prm, a_prm);
        host.stop();
    endtask

    task automatic rd(input int n, output logic [7:0] b [4]);
        logic a;
        host.start();
        host.tx(8'h31, a);
        for (int i = 0; i < n; i++)
            host.rx(i < n - 1, b[i]);
        host.stop();
    endtask

    task automatic poll(output logic [7:0] s);
        logic a;
        int k;
        host.start();
        host.tx(8'h31, a);
        host.rx(1'b1, s);
        chk1(s[STS_BUSY_BIT], 1'b1);
        for (k = 0; k < 200 && s[STS_BUSY_BIT] !== 1'b0; k++)
            host.rx(1'b1, s);
        if (k == 200)
            bail();
        host.rx(1'b0, s);
        host.stop();
    endtask

    task automatic idle_wait();
        int k;
        for (k = 0; k < 500 && busy !== 1'b0; k++)
            @(negedge core_clk);
        if (k == 500)
            bail();
        repeat (4) @(negedge core_clk);
    endtask

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic s_reset();
        logic a1, a2;
        logic [7:0] b [4];
        line_res = 3'b100;
        wr(CMD_LINE_RESET, 8'h00, 1'b0, a1, a2);
        chk1(a1, 1'b1);
        chk1(busy, 1'b1);
        chk1(got_cmd.op === SLMCS_OP_RESET, 1'b1);
        idle_wait();
        rd(1, b);
        chk8(b[0], 8'h01 << STS_PRES_BIT);
    endtask

    task automatic s_refuse();
        logic a1, a2;
        logic [7:0] s;
        logic [7:0] codes [4] = '{CMD_SINGLE_SLOT, CMD_WRITE_BYTE, CMD_PORT_ADJUST,
                                  CMD_LINE_RESET};
        int n0;
        n0 = n_cmds;
        eng_rdy = 1'b0;
        eng_len = 200;
        line_res = 3'b010;
        wr(CMD_LINE_RESET, 8'h00, 1'b0, a1, a2);
        chk1(line_cmd_valid, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            wr(codes[i], 8'h80, 1'b1, a1, a2);
            chk1(a1, 1'b0);
        end
        eng_rdy = 1'b1;
        poll(s);
        chk8(s, 8'h01 << STS_SHORT_BIT);
        chk8(8'(n_cmds - n0), 8'h01);
        eng_len = 40;
    endtask

    task automatic s_slot();
        logic a1, a2;
        logic [7:0] s;
        logic [7:0] b [4];
        line_res = 3'b001;
        eng_len = 200;
        wr(CMD_SINGLE_SLOT, 8'h80, 1'b1, a1, a2);
        chk1(a2, 1'b1);
        chk1(got_cmd.op === SLMCS_OP_SLOT && got_cmd.data === 8'h80, 1'b1);
        poll(s);
        eng_len = 40;
        chk1(s[STS_SLOT_BIT], 1'b1);
        rd(1, b);
        chk1(b[0][STS_SLOT_BIT], 1'b1);
    endtask

    task automatic s_write();
        logic a1, a2;
        logic [7:0] b [4];
        line_res = 3'b000;
        wr(CMD_WRITE_BYTE, 8'h33, 1'b1, a1, a2);
        chk1(a2, 1'b1);
        chk1(got_cmd.op === SLMCS_OP_WRITE, 1'b1);
        chk8(got_cmd.data, 8'h33);
        idle_wait();
        rd(1, b);
        chk1(b[0][STS_BUSY_BIT], 1'b0);
        chk1(b[0][STS_SLOT_BIT], 1'b1);
    endtask

    task automatic s_port();
        logic a1, a2;
        logic [7:0] b [4];
        wr(CMD_PORT_ADJUST, 8'h29, 1'b1, a1, a2);
        chk1(a2, 1'b1);
        rd(4, b);
        for (int i = 0; i < 4; i++)
            chk8(b[i], {4'h0, (i == 1) ? 4'h9 : PORT_PARAM_RST});
        chk8({4'h0, port_params[7:4]}, 8'h09);
        wr(CMD_PORT_ADJUST, 8'he5, 1'b1, a1, a2);
        chk1(a2, 1'b1);
        wr(CMD_WRITE_BYTE, 8'h55, 1'b1, a1, a2);
        idle_wait();
        wr(CMD_POINTER_SET, PTR_CODE_PORT, 1'b1, a1, a2);
        chk1(a2, 1'b1);
        rd(2, b);
        chk8(b[0], {4'h0, PORT_PARAM_RST});
        chk8(b[1], 8'h09);
    endtask

    initial
    begin
        #4000000;
        bail();
    end

    initial
    begin
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (5) @(negedge core_clk);
        chk1(busy, 1'b0);
        chk8({4'h0, port_params[3:0]}, {4'h0, PORT_PARAM_RST});
        s_reset();
        s_refuse();
        s_slot();
        s_write();
        s_port();
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
